// File: logic/amp_cfg_pkg.sv
// Shared constants and types for amplifier mode and oscillator config
package amp_cfg_pkg;
  localparam int CLOCK_HZ = 100_000_000;
  // Frequency constant 12.45e9 Hz*ohm
  localparam longint FREQ_CONST_HZ_OHM = 64'd12450000000;
  localparam int MASTER_MIN_OHM = 26_000;
  // Register map (word offsets as byte addresses)
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] ROSC_OFS   = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] PERIOD_OFS = 4'hC;
  // Control field positions
  localparam int RUN_POS     = 0;
  localparam int MUTE_POS    = 1;
  localparam int HOP_POS     = 3;
  localparam int INPHASE_POS = 5;
  localparam int SHIFT_POS   = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ROSC_RESET = 32'h0000_9858;
  // Spread sweep: +/- 5 percent in 1/1000 steps
  localparam int SPREAD_MIN_PM = 950;
  localparam int SPREAD_MAX_PM = 1050;
  localparam int HOP_LOW_PM    = 900;
  localparam int HOP_HIGH_PM   = 1100;
  localparam int NOMINAL_PM    = 1000;
  localparam logic [15:0] SWEEP_DIV = 16'h03E8;
  // Strap codes, already decoded
  localparam logic [1:0] MODSTRAP_SHORT = 2'h0;
  localparam logic [1:0] MODSTRAP_4K7   = 2'h1;
  localparam logic [1:0] MODSTRAP_13K   = 2'h2;
  localparam logic [1:0] MODSTRAP_33K   = 2'h3;
  localparam logic [1:0] HOP_NONE = 2'h0;
  localparam logic [1:0] HOP_DOWN = 2'h1;
  localparam logic [1:0] HOP_UP   = 2'h2;
  typedef enum {ST_OFF, ST_STANDBY, ST_MUTE, ST_OPERATE} amp_state_t;
endpackage

// File: logic/strap_if.sv
// Interface carrying synchronised and latched strap settings
`timescale 1ns/1ns
interface strap_if;
  logic       bus_mode;
  logic       clk_master;
  logic       loop_net;
  logic       inphase;
  logic       half_shift;
  logic       parallel;
  modport src (output bus_mode, clk_master, loop_net, inphase,
               half_shift, parallel);
  modport dst (input bus_mode, clk_master, loop_net, inphase,
               half_shift, parallel);
endinterface

// File: logic/strap_capture.sv
// Synchronises the pin straps and latches the operation strap
`timescale 1ns/1ns
module strap_capture (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       addr_strap_gnd,
  input  wire logic       fset_master,
  input  wire logic       ssm_network,
  input  wire logic [2:0] op_strap,
  input  wire logic       switching,
  strap_if.src            st
);
  import amp_cfg_pkg::*;
  logic [5:0] s1_reg, s2_reg, s3_reg, val_reg;
  logic [5:0] s1_next, s2_next, s3_next, val_next;
  logic       latched_reg, latched_next;
  logic [2:0] op_reg, op_next;

  always_comb begin
    s1_next = {addr_strap_gnd, fset_master, ssm_network, op_strap};
    s2_next = s1_reg;
    s3_next = s2_reg;
    val_next = val_reg;
    if (s2_reg == s3_reg) begin
      val_next = s3_reg;
    end
    latched_next = latched_reg;
    op_next = op_reg;
    // Strap is frozen once outputs switch, so switching noise is ignored
    if (!latched_reg) begin
      op_next = val_reg[2:0];
      if (switching) begin
        latched_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1_reg      <= 6'h00;
      s2_reg      <= 6'h00;
      s3_reg      <= 6'h00;
      val_reg     <= 6'h00;
      latched_reg <= 1'b0;
      op_reg      <= 3'h0;
    end else begin
      s1_reg      <= s1_next;
      s2_reg      <= s2_next;
      s3_reg      <= s3_next;
      val_reg     <= val_next;
      latched_reg <= latched_next;
      op_reg      <= op_next;
    end
  end

  assign st.bus_mode   = !val_reg[5];
  assign st.clk_master = val_reg[4];
  assign st.loop_net   = val_reg[3];
  // Strap code bit 2 = parallel; bits 1:0 = resistor decode
  assign st.parallel   = op_reg[2];
  assign st.inphase    = (op_reg[1:0] == MODSTRAP_4K7) ||
                         (op_reg[1:0] == MODSTRAP_33K);
  assign st.half_shift = (op_reg[1:0] == MODSTRAP_13K) ||
                         (op_reg[1:0] == MODSTRAP_33K);
endmodule

// File: logic/osc_gen.sv
// Switching clock generator: master divider with spread/hop, slave follow
`timescale 1ns/1ns
module osc_gen (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        master,
  input  wire logic        spread_en,
  input  wire logic [1:0]  hop,
  input  wire logic [31:0] rosc_ohm,
  input  wire logic        ext_clk_sync,
  input  wire logic        lock_en,
  input  wire logic        half_shift,
  output logic             sw_tick,
  output logic [31:0]      period_cycles
);
  import amp_cfg_pkg::*;
  logic [31:0] cnt_reg, cnt_next, per_reg, per_next;
  logic [10:0] pm_reg, pm_next;
  logic        up_reg, up_next, tick_reg, tick_next, prev_reg, prev_next;
  logic [15:0] sw_reg, sw_next;
  logic [31:0] slave_cnt_reg, slave_cnt_next, ext_per_reg, ext_per_next;
  logic [63:0] prod;
  logic [31:0] nom;

  always_comb begin
    // Half period = CLOCK_HZ*R/(2*12.45e9); pm/1000 scales the frequency
    // Limitation: R above about 184 megohm overflows the 64-bit product
    prod = (64'(CLOCK_HZ) * 64'(rosc_ohm) * 64'(NOMINAL_PM))
           / (64'h2 * FREQ_CONST_HZ_OHM * 64'(pm_reg));
    nom = (prod[31:0] == 32'h0) ? 32'h1 : prod[31:0];
    pm_next = pm_reg;
    up_next = up_reg;
    sw_next = sw_reg + 16'h1;
    if (!master || !spread_en) begin
      pm_next = 11'(NOMINAL_PM);
      if (master && hop == HOP_DOWN) pm_next = 11'(HOP_LOW_PM);
      if (master && hop == HOP_UP) pm_next = 11'(HOP_HIGH_PM);
      sw_next = 16'h0;
    end else if (sw_reg >= SWEEP_DIV) begin
      sw_next = 16'h0;
      if (up_reg) begin
        if (pm_reg >= 11'(SPREAD_MAX_PM)) up_next = 1'b0;
        else pm_next = pm_reg + 11'h1;
      end else begin
        if (pm_reg <= 11'(SPREAD_MIN_PM)) up_next = 1'b1;
        else pm_next = pm_reg - 11'h1;
      end
    end
    prev_next = ext_clk_sync;
    slave_cnt_next = slave_cnt_reg + 32'h1;
    ext_per_next = ext_per_reg;
    tick_next = 1'b0;
    cnt_next = cnt_reg + 32'h1;
    per_next = per_reg;
    if (master) begin
      if (cnt_reg + 32'h1 >= nom) begin
        cnt_next = 32'h0;
        tick_next = 1'b1;
        per_next = nom;
      end
    end else begin
      if (ext_clk_sync && !prev_reg) begin
        ext_per_next = slave_cnt_reg + 32'h1;
        slave_cnt_next = 32'h0;
        if (!lock_en) begin
          tick_next = 1'b1;
          cnt_next = 32'h0;
        end
      end
      per_next = ext_per_reg;
      // Locked: regenerate, offset by a quarter period for half-pi shift
      if (lock_en && ext_per_reg != 32'h0 &&
          slave_cnt_reg == (half_shift ? (ext_per_reg >> 2) : 32'h0)) begin
        tick_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_reg <= 32'h0;
      per_reg <= 32'h0;
      pm_reg <= 11'(NOMINAL_PM);
      up_reg <= 1'b1;
      tick_reg <= 1'b0;
      prev_reg <= 1'b0;
      sw_reg <= 16'h0;
      slave_cnt_reg <= 32'h0;
      ext_per_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_next;
      per_reg <= per_next;
      pm_reg <= pm_next;
      up_reg <= up_next;
      tick_reg <= tick_next;
      prev_reg <= prev_next;
      sw_reg <= sw_next;
      slave_cnt_reg <= slave_cnt_next;
      ext_per_reg <= ext_per_next;
    end
  end
  assign sw_tick = tick_reg;
  assign period_cycles = per_reg;
endmodule

// File: logic/amp_mode_and_oscillator_config.sv
// Top: mode decode, Avalon-MM registers, strap and oscillator control
// Functional notes
// - Bus mode: enable pin low means off; enable high, run clear is standby.
// - Bus mode, enable and run set: mute bit selects mute or operate.
// - Pin mode: enable low off; else mute pin held mutes, released operates.
// - Bus address strap grounded selects pin mode, otherwise bus mode.
// - Frequency-set resistor above threshold: master, drive clock out.
// - Frequency-set shorted: slave, shared clock pin is input.
// - Master switching frequency equals constant divided by resistance.
// - Spread and hop only as master; stagger and lock only as slave.
// - Master: capacitor on spread pin enables spread, grounded disables.
// - Spread sweeps frequency triangularly between 95 and 105 percent.
// - Bus master mode, spread off: hop field gives 90, 110 percent or nominal.
// - Slave: loop network enables PLL; grounded pin uses clock directly.
// - Phase staggering applies only with PLL enabled in slave mode.
// - Pin mode: strap selects modulation, half-pi shift and parallel.
// - Bus mode: strap selects parallel only; rest from bus bits.
// - Strap: short AD, 4.7k in-phase, 13k AD+shift, 33k in-phase+shift.
// - Operation strap latched when outputs start switching, then held.
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ns
module amp_mode_and_oscillator_config (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        device_on_pin,
  input  wire logic        mute_pin_held,
  input  wire logic        bus_address_strap_gnd,
  input  wire logic        frequency_set_master,
  input  wire logic        spread_loop_network,
  input  wire logic [2:0]  operation_select_strap,
  input  wire logic        shared_clock_pin_i,
  output logic             shared_clock_pin_o,
  output logic             shared_clock_pin_oe,
  output logic             outputs_switching,
  output logic             audio_unmuted,
  output logic             in_phase_scheme,
  output logic             half_pi_shift,
  output logic             parallel_mode,
  output logic             spread_active,
  output logic             pll_active,
  output logic [1:0]       amp_state
);
  import amp_cfg_pkg::*;

  strap_if st ();

  logic [2:0] en_s_reg, mu_s_reg, ck_s_reg;
  logic [2:0] en_s_next, mu_s_next, ck_s_next;
  logic       en_reg, mu_reg, ck_reg, en_next, mu_next, ck_next;
  logic [31:0] ctrl_reg, ctrl_next, rosc_reg, rosc_next;
  logic [31:0] rd_reg, rd_next;
  logic        wait_reg, wait_next;
  amp_state_t  state_reg, state_next;
  logic        sw_tick;
  logic [31:0] period_cycles;
  logic        lvl_reg, lvl_next;
  logic        master_w, spread_w, lock_w, inph_w, shift_w;
  logic [1:0]  hop_w;
  logic [31:0] status_w;
  logic        o_clk_reg, o_oe_reg, o_sw_reg, o_un_reg, o_inph_reg;
  logic        o_sh_reg, o_par_reg, o_spr_reg, o_pll_reg;
  logic [1:0]  o_st_reg;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction

  strap_capture u_strap (
    .clock          (clock),
    .sys_rst        (sys_rst),
    .addr_strap_gnd (bus_address_strap_gnd),
    .fset_master    (frequency_set_master),
    .ssm_network    (spread_loop_network),
    .op_strap       (operation_select_strap),
    .switching      (o_sw_reg),
    .st             (st)
  );

  // Option enables gated by clock role, except the in-phase select
  always_comb begin
    master_w = st.clk_master;
    spread_w = master_w && st.loop_net;
    hop_w = (master_w && st.bus_mode) ? ctrl_reg[HOP_POS +: 2] : HOP_NONE;
    lock_w = !master_w && st.loop_net;
    if (st.bus_mode) begin
      inph_w = ctrl_reg[INPHASE_POS];
      shift_w = ctrl_reg[SHIFT_POS];
    end else begin
      inph_w = st.inphase;
      shift_w = st.half_shift;
    end
    shift_w = shift_w && lock_w;
  end

  osc_gen u_osc (
    .clock         (clock),
    .sys_rst       (sys_rst),
    .master        (master_w),
    .spread_en     (spread_w),
    .hop           (hop_w),
    .rosc_ohm      (rosc_reg),
    .ext_clk_sync  (ck_reg),
    .lock_en       (lock_w),
    .half_shift    (shift_w),
    .sw_tick       (sw_tick),
    .period_cycles (period_cycles)
  );

  // Pin synchronisers: accept a change once stages two and three agree
  always_comb begin
    en_s_next = {en_s_reg[1:0], device_on_pin};
    mu_s_next = {mu_s_reg[1:0], mute_pin_held};
    ck_s_next = {ck_s_reg[1:0], shared_clock_pin_i};
    en_next = (en_s_reg[1] == en_s_reg[2]) ? en_s_reg[2] : en_reg;
    mu_next = (mu_s_reg[1] == mu_s_reg[2]) ? mu_s_reg[2] : mu_reg;
    ck_next = (ck_s_reg[1] == ck_s_reg[2]) ? ck_s_reg[2] : ck_reg;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      en_s_reg <= 3'h0;
      mu_s_reg <= 3'h0;
      ck_s_reg <= 3'h0;
      en_reg <= 1'b0;
      mu_reg <= 1'b0;
      ck_reg <= 1'b0;
    end else begin
      en_s_reg <= en_s_next;
      mu_s_reg <= mu_s_next;
      ck_s_reg <= ck_s_next;
      en_reg <= en_next;
      mu_reg <= mu_next;
      ck_reg <= ck_next;
    end
  end

  // Mode decode
  always_comb begin
    state_next = state_reg;
    if (!en_reg) begin
      state_next = ST_OFF;
    end else if (st.bus_mode) begin
      if (!ctrl_reg[RUN_POS]) state_next = ST_STANDBY;
      else if (ctrl_reg[MUTE_POS]) state_next = ST_MUTE;
      else state_next = ST_OPERATE;
    end else begin
      if (mu_reg) state_next = ST_MUTE;
      else state_next = ST_OPERATE;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) state_reg <= ST_OFF;
    else state_reg <= state_next;
  end

  // Bus side; while off the device ignores control writes and holds control at reset; oscillator writes still land
  assign status_w = {22'h0, hop_w, lock_w, spread_w, master_w,
                     st.bus_mode, st.parallel, shift_w, inph_w,
                     (state_reg == ST_OPERATE)};

  always_comb begin
    ctrl_next = ctrl_reg;
    rosc_next = rosc_reg;
    rd_next = rd_reg;
    wait_next = 1'b1;
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
      rd_next = 32'h0;
      case (avs_address)
        CTRL_OFS: rd_next = ctrl_reg;
        ROSC_OFS: rd_next = rosc_reg;
        STATUS_OFS: rd_next = status_w;
        PERIOD_OFS: rd_next = period_cycles;
        default: rd_next = 32'h0;
      endcase
    end
    // Write lands only on the edge where waitrequest is seen low
    if (avs_write && !wait_reg) begin
      if (avs_address == CTRL_OFS && en_reg) begin
        ctrl_next = merge(ctrl_reg, avs_writedata, avs_byteenable);
      end
      if (avs_address == ROSC_OFS) begin
        rosc_next = merge(rosc_reg, avs_writedata, avs_byteenable);
      end
    end
    if (!en_reg) ctrl_next = CTRL_RESET;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RESET;
      rosc_reg <= ROSC_RESET;
      rd_reg <= 32'h0;
      wait_reg <= 1'b1;
    end else begin
      ctrl_reg <= ctrl_next;
      rosc_reg <= rosc_next;
      rd_reg <= rd_next;
      wait_reg <= wait_next;
    end
  end

  // Shared clock output toggles per half switching period
  always_comb begin
    lvl_next = lvl_reg;
    if (sw_tick) lvl_next = !lvl_reg;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lvl_reg <= 1'b0;
      o_clk_reg <= 1'b0;
      o_oe_reg <= 1'b0;
      o_sw_reg <= 1'b0;
      o_un_reg <= 1'b0;
      o_inph_reg <= 1'b0;
      o_sh_reg <= 1'b0;
      o_par_reg <= 1'b0;
      o_spr_reg <= 1'b0;
      o_pll_reg <= 1'b0;
      o_st_reg <= 2'h0;
    end else begin
      lvl_reg <= lvl_next;
      o_clk_reg <= lvl_next && master_w;
      o_oe_reg <= master_w;
      o_sw_reg <= (state_reg == ST_MUTE) || (state_reg == ST_OPERATE);
      o_un_reg <= (state_reg == ST_OPERATE);
      o_inph_reg <= inph_w;
      o_sh_reg <= shift_w;
      o_par_reg <= st.parallel;
      o_spr_reg <= spread_w;
      o_pll_reg <= lock_w;
      o_st_reg <= 2'(state_reg);
    end
  end

  assign avs_readdata = rd_reg;
  assign avs_waitrequest = wait_reg;
  assign shared_clock_pin_o = o_clk_reg;
  assign shared_clock_pin_oe = o_oe_reg;
  assign outputs_switching = o_sw_reg;
  assign audio_unmuted = o_un_reg;
  assign in_phase_scheme = o_inph_reg;
  assign half_pi_shift = o_sh_reg;
  assign parallel_mode = o_par_reg;
  assign spread_active = o_spr_reg;
  assign pll_active = o_pll_reg;
  assign amp_state = o_st_reg;
endmodule

// File: verification/amp_cfg_monitor.sv
// Concurrent checks on the mode and oscillator config ports
`timescale 1ns/1ns
module amp_cfg_monitor (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       device_on_pin,
  input wire logic       mute_pin_held,
  input wire logic       bus_address_strap_gnd,
  input wire logic       frequency_set_master,
  input wire logic [2:0] operation_select_strap,
  input wire logic       shared_clock_pin_oe,
  input wire logic       outputs_switching,
  input wire logic       in_phase_scheme,
  input wire logic       parallel_mode,
  input wire logic       spread_active,
  input wire logic       pll_active,
  input wire logic [1:0] amp_state
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Eight cycles cover the pin synchroniser and the state register
  off_when_low_a: assert property (!device_on_pin [*8]
    |-> amp_state == 2'h0) else $error("state not off with enable low");
  pin_operate_a: assert property ((bus_address_strap_gnd && device_on_pin
    && !mute_pin_held) [*8] |-> amp_state == 2'h3)
    else $error("pin mode not operating");
  pin_mute_a: assert property ((bus_address_strap_gnd && device_on_pin
    && mute_pin_held) [*8] |-> amp_state == 2'h2)
    else $error("pin mode not muted");
  master_oe_a: assert property (frequency_set_master [*8]
    |-> shared_clock_pin_oe) else $error("master not driving clock pin");
  slave_oe_a: assert property (!frequency_set_master [*8]
    |-> !shared_clock_pin_oe) else $error("slave driving clock pin");
  spread_master_a: assert property (spread_active |-> shared_clock_pin_oe)
    else $error("spread active outside master");
  pll_slave_a: assert property (pll_active |-> !shared_clock_pin_oe)
    else $error("lock active outside slave");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest) // CONTRACT
    else $error("waitrequest low for more than one cycle");
  wait_answer_a: assert property ($rose(avs_read || avs_write) |=> // CONTRACT
    !avs_waitrequest) else $error("bus answer late");
  off_silent_a: assert property (amp_state == 2'h0 |-> !outputs_switching)
    else $error("outputs switching while off");
  pin_decode_a: assert property ((bus_address_strap_gnd && outputs_switching)
    [*8] |-> in_phase_scheme == operation_select_strap[0]
    && parallel_mode == operation_select_strap[2])
    else $error("operation strap decoded wrongly");
endmodule
bind amp_mode_and_oscillator_config amp_cfg_monitor amp_cfg_monitor_i (
  .clock, .sys_rst, .avs_read, .avs_write, .avs_waitrequest, .device_on_pin,
  .mute_pin_held, .bus_address_strap_gnd, .frequency_set_master,
  .operation_select_strap, .shared_clock_pin_oe, .outputs_switching,
  .in_phase_scheme, .parallel_mode, .spread_active, .pll_active, .amp_state);

// File: verification/ext_clock_src.sv
// Free-running external switching clock feeding slave amplifiers
`timescale 1ns/1ns
module ext_clock_src #(
  parameter int HALF = 40
) (
  input  wire logic clock,
  input  wire logic run,
  output logic      ext_clk
);
  int cnt = 0;
  initial ext_clk = 1'b0;
  // Never gated by device state, so slaves can finish shutting down
  always @(posedge clock) begin
    if (!run) begin
      cnt <= 0;
      ext_clk <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      ext_clk <= !ext_clk;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// File: verification/amp_mode_and_oscillator_config_tb_top.sv
// Self-checking bench for the amplifier mode and oscillator config block
`timescale 1ns/1ns
module amp_mode_and_oscillator_config_tb_top;
  import amp_cfg_pkg::*;
  logic        clock, sys_rst, avs_read, avs_write, avs_waitrequest, ext_run;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        device_on_pin, mute_pin_held, bus_address_strap_gnd, ext_clk;
  logic        frequency_set_master, spread_loop_network, parallel_mode;
  logic [2:0]  operation_select_strap;
  logic        shared_clock_pin_o, shared_clock_pin_oe, outputs_switching;
  logic        audio_unmuted, in_phase_scheme, half_pi_shift, spread_active;
  logic        pll_active;
  logic [1:0]  amp_state;
  wire         shared_clock_pin_i = shared_clock_pin_oe ? shared_clock_pin_o
                                                       : ext_clk;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          j, n;

  amp_mode_and_oscillator_config amp_mode_and_oscillator_config_i (
    .clock, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .device_on_pin,
    .mute_pin_held, .bus_address_strap_gnd, .frequency_set_master,
    .spread_loop_network, .operation_select_strap, .shared_clock_pin_i,
    .shared_clock_pin_o, .shared_clock_pin_oe, .outputs_switching,
    .audio_unmuted, .in_phase_scheme, .half_pi_shift, .parallel_mode,
    .spread_active, .pll_active, .amp_state);
  ext_clock_src ext_clock_src_i (.clock(clock), .run(ext_run),
                                 .ext_clk(ext_clk));

  // Cycles between pin toggles: half of one switching period
  function automatic logic [31:0] half_cyc(longint r, int pm);
    return 32'((64'(CLOCK_HZ) * r * 64'(NOMINAL_PM)) /
               (64'h2 * FREQ_CONST_HZ_OHM * 64'(pm)));
  endfunction
  function automatic logic [31:0] half_exp(int k, logic [1:0] hop);
    return half_cyc(1245 * k, (hop == HOP_DOWN) ? HOP_LOW_PM
                    : (hop == HOP_UP) ? HOP_HIGH_PM : NOMINAL_PM);
  endfunction
  function automatic logic [1:0] state_exp(logic run, logic mute);
    return !run ? 2'h1 : mute ? 2'h2 : 2'h3;
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d, logic [3:0] be,
                     output logic [31:0] rq);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    rq = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, 4'hF, dummy);
  endtask
  task automatic cfg(logic bus_address_strap, logic mst, logic net, logic [2:0] s);
    sys_rst <= 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} <= '0;
    avs_byteenable <= 4'hF;
    {device_on_pin, mute_pin_held} <= 2'b00;
    {bus_address_strap_gnd, frequency_set_master} <= {bus_address_strap, mst};
    spread_loop_network <= net;
    operation_select_strap <= s;
    ext_run <= !mst;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
  task automatic pins(logic on, logic mute);
    device_on_pin <= on;
    mute_pin_held <= mute;
    repeat (12) @(posedge clock);
  endtask
  task automatic measure(output int c);
    logic prev;
    prev = shared_clock_pin_o;
    // First pass aligns to a toggle, second counts a full half period
    for (int k = 0; k < 2; k++) begin
      c = 0;
      while (shared_clock_pin_o === prev && c < 2000) begin
        @(posedge clock);
        c++;
      end
      prev = shared_clock_pin_o;
    end
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #900000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h4329));
    cfg(1'b0, 1'b1, 1'b0, 3'b100);
    bus(1'b0, CTRL_OFS, 32'h0, 4'hF, q);
    chk("ctrl reset", CTRL_RESET, q);
    bus(1'b0, ROSC_OFS, 32'h0, 4'hF, q);
    chk("rosc reset", ROSC_RESET, q);
    wr(4'h2, 32'hFFFF_FFFF);
    bus(1'b0, 4'h2, 32'h0, 4'hF, q);
    chk("unmapped", 32'h0, q);
    pins(1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(CTRL_OFS, {30'h0, i[0], i[1]});
      repeat (12) @(posedge clock);
      chk("state", state_exp(i[1], i[0]), amp_state);
      chk("unmuted", i[1] & !i[0], audio_unmuted);
    end
    pins(1'b0, 1'b0);
    chk("state off", 2'h0, amp_state);
    wr(CTRL_OFS, 32'h1);
    bus(1'b0, CTRL_OFS, 32'h0, 4'hF, q);
    chk("ctrl while off", 32'h0, q);
    pins(1'b1, 1'b0);
    wr(CTRL_OFS, 32'h21);
    repeat (12) @(posedge clock);
    chk("bus in phase", 1, in_phase_scheme);
    chk("parallel", 1, parallel_mode);
    operation_select_strap <= 3'b000;
    repeat (12) @(posedge clock);
    chk("parallel held", 1, parallel_mode);
    chk("clock out", 1, shared_clock_pin_oe);
    $display("test bus mode done");
    j = 24 + $urandom_range(16);
    wr(ROSC_OFS, 32'(1245 * j));
    bus(1'b1, ROSC_OFS, 32'hFFFF_FFFF, 4'h2, q);
    bus(1'b0, ROSC_OFS, 32'h0, 4'hF, q);
    chk("rosc merge", (32'(1245 * j) & 32'hFFFF_00FF) | 32'h0000_FF00, q);
    wr(ROSC_OFS, 32'(1245 * j));
    for (int h = 0; h < 4; h++) begin
      wr(CTRL_OFS, {27'h0, h[1:0], 3'b001});
      repeat (1000) @(posedge clock);
      bus(1'b0, PERIOD_OFS, 32'h0, 4'hF, q);
      chk("half period", half_exp(j, h[1:0]), q);
      measure(n);
      chk("pin half period", half_exp(j, h[1:0]), 32'(n));
    end
    $display("test hop done");
    cfg(1'b0, 1'b1, 1'b1, 3'b000);
    pins(1'b1, 1'b0);
    wr(ROSC_OFS, 32'd124500);
    wr(CTRL_OFS, 32'h1);
    chk("spread", 1, spread_active);
    chk("lock in master", 0, pll_active);
    j = half_cyc(124500, SPREAD_MAX_PM);
    n = half_cyc(124500, SPREAD_MIN_PM);
    repeat (5) begin
      repeat (3000) @(posedge clock);
      bus(1'b0, PERIOD_OFS, 32'h0, 4'hF, q);
      chk("spread span", 1, 32'(q >= j && q <= n));
    end
    $display("test spread done");
    for (int p = 1; p >= 0; p--) begin
      cfg(1'b0, 1'b0, p[0], 3'b000);
      pins(1'b1, 1'b0);
      wr(CTRL_OFS, 32'h41);
      repeat (12) @(posedge clock);
      chk("slave oe", 0, shared_clock_pin_oe);
      chk("lock", p[0], pll_active);
      chk("stagger", p[0], half_pi_shift);
      chk("spread in slave", 0, spread_active);
      chk("slave state", 2'h3, amp_state);
      // Long enough for one full external period after a partial one
      repeat (200) @(posedge clock);
      bus(1'b0, PERIOD_OFS, 32'h0, 4'hF, q);
      chk("ext period", 32'd80, q);
      pins(1'b0, 1'b0);
      chk("slave off", 2'h0, amp_state);
    end
    $display("test slave done");
    for (int s = 0; s < 8; s++) begin
      cfg(1'b1, 1'b0, 1'b1, s[2:0]);
      pins(1'b1, 1'b0);
      chk("pin operate", 2'h3, amp_state);
      chk("pin in phase", s[0], in_phase_scheme);
      chk("pin shift", s[1], half_pi_shift);
      chk("pin parallel", s[2], parallel_mode);
      pins(1'b1, 1'b1);
      chk("pin mute", 2'h2, amp_state);
    end
    pins(1'b0, 1'b1);
    chk("pin off", 2'h0, amp_state);
    $display("test pin mode done");
    report_and_stop();
  end
endmodule
